// File: inc/cgr_regs.vh
// Register offsets, field positions and reset values of the global configuration bank
`ifndef CGR_REGS_VH
`define CGR_REGS_VH

`define CGR_ADDR_W          8
`define CGR_DATA_W          8

`define CGR_OFF_BANK        8'h00
`define CGR_OFF_MCR_ONE     8'h01
`define CGR_OFF_MCR_TWO     8'h02
`define CGR_OFF_PLL_EN      8'h03
`define CGR_OFF_IN_EN       8'h04
`define CGR_OFF_OUT_EN_LO   8'h05
`define CGR_OFF_OUT_EN_HI   8'h06
`define CGR_OFF_MUX_ONE     8'h07
`define CGR_OFF_MUX_TWO     8'h08

`define CGR_RST_VAL         8'h00

`define CGR_MASK_BANK       8'h80
`define CGR_MASK_MCR_ONE    8'hEA
`define CGR_MASK_MCR_TWO    8'hF7
`define CGR_MASK_PLL_EN     8'h01
`define CGR_MASK_IN_EN      8'h07
`define CGR_MASK_OUT_EN_LO  8'hFF
`define CGR_MASK_OUT_EN_HI  8'h03
`define CGR_MASK_MUX        8'h3F

`define CGR_BIT_NVM_SEL     7
`define CGR_BIT_SOFT_RST    7
`define CGR_BIT_HARD_RST    6
`define CGR_BIT_STOP        5
`define CGR_BIT_ROSC_DIS    3
`define CGR_BIT_OD_OUT      1
`define CGR_BIT_DBL         2
`define CGR_BIT_PLL_EN      0

`define CGR_OSC_OFF         2'b00
`define CGR_OSC_XTAL        2'b01
`define CGR_OSC_SE          2'b10

`define CGR_MUX_INT         2'b00
`define CGR_MUX_FRAC        2'b01
`define CGR_MUX_PATH2       2'b11

`define CGR_ROUTE_REGS      2'b00
`define CGR_ROUTE_NVM       2'b01
`define CGR_ROUTE_ROM       2'b10

`endif

// File: src/cgr_global_cfg.v
// Global configuration register bank of the clock generator
`timescale 1ns/100ps
`include "cgr_regs.vh"

// Function
// - Bit 7 at offset zero maps nonvolatile memory above address zero when present.
// - ROM bank select takes precedence over the nonvolatile memory bank select.
// - Soft reset clears everything but host port, reset bits, address and status.
// - Soft reset neither captures pin defaults nor starts the boot controller.
// - Hard reset bit acts as reset pin, capturing pins and starting boot.
// - Each output stop is global stop OR own stop, when source is global.
// - Ring oscillator powered down while its disable bit is one.
// - Data-out pin drives both levels, or only low in open-drain mode.
// - Doubler enable bit powers the clock doubler up or down.
// - Oscillator pin mode: off, crystal, single-ended input, unused.
// - Bit 0 at 03h enables the analog PLL.
// - Three input clock enable bits power input receivers and dividers.
// - Ten output enable bits power each output's dividers and stop logic.
// - Group mux codes: integer, fractional or bypass, path 2; 10 unused.
// - Mux fields at 07h and 08h serve groups A to C and D to F.
// - Bits 1:0 at 08h serve the group of outputs 6 and 7.
module cgr_global_cfg #(
    parameter       HAS_NVM  = 1,
    parameter       N_OUT    = 10,
    parameter       N_IN     = 3,
    parameter       N_GROUP  = 6
) (
    input  wire                   clk,
    input  wire                   rst_b,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    input  wire [`CGR_ADDR_W-1:0] reg_addr,
    input  wire [`CGR_DATA_W-1:0] reg_wdata,
    output reg  [`CGR_DATA_W-1:0] reg_rdata,
    output reg                    reg_rd_valid,
    input  wire                   rom_bank_select,
    output reg  [1:0]             bank_route,
    input  wire                   data_out_bit,
    input  wire                   data_out_drive,
    output reg                    data_out_o,
    output reg                    data_out_oe,
    input  wire [N_OUT-1:0]       per_output_stop_regs,
    input  wire [N_OUT-1:0]       stop_source_global,
    output wire [N_OUT-1:0]       out_stop,
    output reg  [N_OUT-1:0]       output_clock_enable,
    output reg  [N_OUT-1:0]       out_src_int,
    output reg  [N_OUT-1:0]       out_src_frac,
    output reg  [N_OUT-1:0]       out_src_path2,
    output reg  [N_IN-1:0]        input_clock_enable,
    output reg                    pll_enable,
    output reg                    clock_doubler_enable,
    output reg                    ring_osc_disable,
    output reg                    xtal_driver_en,
    output reg                    osc_se_input_en,
    output reg                    osc_pin_b_float,
    output reg                    soft_reset_out,
    output wire                   strap_capture,
    output wire                   boot_start
);

    // Register storage
    reg [`CGR_DATA_W-1:0] bank_reg;
    reg [`CGR_DATA_W-1:0] mcr_one_reg;
    reg [`CGR_DATA_W-1:0] mcr_two_reg;
    reg [`CGR_DATA_W-1:0] pll_en_reg;
    reg [`CGR_DATA_W-1:0] in_en_reg;
    reg [`CGR_DATA_W-1:0] out_en_lo_reg;
    reg [`CGR_DATA_W-1:0] out_en_hi_reg;
    reg [`CGR_DATA_W-1:0] mux_one_reg;
    reg [`CGR_DATA_W-1:0] mux_two_reg;

    wire                  core_reset;
    wire                  soft_bit;
    wire                  hard_bit;
    wire                  global_stop;
    wire                  nvm_bank_select;
    wire                  upper_redirect;
    wire                  regs_visible;
    wire                  wr_hit;
    wire [1:0]            route_next;
    wire [15:0]           out_en_all;
    wire [`CGR_DATA_W-1:0] wdata_mcr_one;
    reg  [`CGR_DATA_W-1:0] rdata_next;
    reg  [1:0]            group_code [0:N_GROUP-1];

    assign soft_bit        = mcr_one_reg[`CGR_BIT_SOFT_RST];
    assign hard_bit        = mcr_one_reg[`CGR_BIT_HARD_RST];
    assign global_stop     = mcr_one_reg[`CGR_BIT_STOP];
    assign nvm_bank_select = (HAS_NVM != 0) & bank_reg[`CGR_BIT_NVM_SEL];

    // ROM select wins, so the bank bit is only consulted without it
    assign route_next = rom_bank_select ? `CGR_ROUTE_ROM :
                        nvm_bank_select ? `CGR_ROUTE_NVM : `CGR_ROUTE_REGS;

    // Offset zero always reaches this bank, higher ones only in register mode
    assign upper_redirect = (route_next != `CGR_ROUTE_REGS);
    assign regs_visible   = (reg_addr == `CGR_OFF_BANK) || !upper_redirect;
    assign wr_hit         = reg_wr && regs_visible;

    assign out_en_all = {out_en_hi_reg, out_en_lo_reg};

    // Hard bit always writable, soft bit unless the hard bit is set; other bits held at zero while reset is held
    assign wdata_mcr_one = reg_wdata & `CGR_MASK_MCR_ONE;

    cgr_reset_ctl u_reset_ctl (
        .clk            (clk),
        .rst_b          (rst_b),
        .soft_reset_bit (soft_bit),
        .hard_reset_bit (hard_bit),
        .core_reset     (core_reset),
        .strap_capture  (strap_capture),
        .boot_start     (boot_start)
    );

    // First master register in one process; reset bits outlive the resets they cause
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mcr_one_reg <= `CGR_RST_VAL;
        end else begin
            // Soft bit: only the pin, the hard bit or a write of zero clear it
            if (hard_bit) begin
                mcr_one_reg[`CGR_BIT_SOFT_RST] <= 1'b0;
            end else if (wr_hit && reg_addr == `CGR_OFF_MCR_ONE) begin
                mcr_one_reg[`CGR_BIT_SOFT_RST] <= wdata_mcr_one[`CGR_BIT_SOFT_RST];
            end
            // Hard bit survives every reset but the pin
            if (wr_hit && reg_addr == `CGR_OFF_MCR_ONE) begin
                mcr_one_reg[`CGR_BIT_HARD_RST] <= wdata_mcr_one[`CGR_BIT_HARD_RST];
            end
            if (core_reset || soft_bit || hard_bit) begin
                mcr_one_reg[5:0] <= 6'h00;
            end else if (wr_hit && reg_addr == `CGR_OFF_MCR_ONE) begin
                mcr_one_reg[5:0] <= wdata_mcr_one[5:0];
            end
        end
    end

    // Plain configuration registers
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bank_reg      <= `CGR_RST_VAL;
            mcr_two_reg   <= `CGR_RST_VAL;
            pll_en_reg    <= `CGR_RST_VAL;
            in_en_reg     <= `CGR_RST_VAL;
            out_en_lo_reg <= `CGR_RST_VAL;
            out_en_hi_reg <= `CGR_RST_VAL;
            mux_one_reg   <= `CGR_RST_VAL;
            mux_two_reg   <= `CGR_RST_VAL;
        end else if (core_reset || soft_bit || hard_bit) begin
            bank_reg      <= `CGR_RST_VAL;
            mcr_two_reg   <= `CGR_RST_VAL;
            pll_en_reg    <= `CGR_RST_VAL;
            in_en_reg     <= `CGR_RST_VAL;
            out_en_lo_reg <= `CGR_RST_VAL;
            out_en_hi_reg <= `CGR_RST_VAL;
            mux_one_reg   <= `CGR_RST_VAL;
            mux_two_reg   <= `CGR_RST_VAL;
        end else if (wr_hit) begin
            case (reg_addr)
                `CGR_OFF_BANK: begin
                    bank_reg <= reg_wdata & `CGR_MASK_BANK;
                end
                `CGR_OFF_MCR_TWO: begin
                    // Monitor bits stored as written, they steer nothing here
                    mcr_two_reg <= reg_wdata & `CGR_MASK_MCR_TWO;
                end
                `CGR_OFF_PLL_EN: begin
                    pll_en_reg <= reg_wdata & `CGR_MASK_PLL_EN;
                end
                `CGR_OFF_IN_EN: begin
                    in_en_reg <= reg_wdata & `CGR_MASK_IN_EN;
                end
                `CGR_OFF_OUT_EN_LO: begin
                    out_en_lo_reg <= reg_wdata & `CGR_MASK_OUT_EN_LO;
                end
                `CGR_OFF_OUT_EN_HI: begin
                    out_en_hi_reg <= reg_wdata & `CGR_MASK_OUT_EN_HI;
                end
                `CGR_OFF_MUX_ONE: begin
                    mux_one_reg <= reg_wdata & `CGR_MASK_MUX;
                end
                `CGR_OFF_MUX_TWO: begin
                    mux_two_reg <= reg_wdata & `CGR_MASK_MUX;
                end
                default: begin
                    bank_reg <= bank_reg;
                end
            endcase
        end
    end

    // Read mux; unmapped or redirected offsets answer zero
    always @* begin
        rdata_next = `CGR_RST_VAL;
        if (regs_visible) begin
            case (reg_addr)
                `CGR_OFF_BANK:      rdata_next = bank_reg;
                `CGR_OFF_MCR_ONE:   rdata_next = mcr_one_reg;
                `CGR_OFF_MCR_TWO:   rdata_next = mcr_two_reg;
                `CGR_OFF_PLL_EN:    rdata_next = pll_en_reg;
                `CGR_OFF_IN_EN:     rdata_next = in_en_reg;
                `CGR_OFF_OUT_EN_LO: rdata_next = out_en_lo_reg;
                `CGR_OFF_OUT_EN_HI: rdata_next = out_en_hi_reg;
                `CGR_OFF_MUX_ONE:   rdata_next = mux_one_reg;
                `CGR_OFF_MUX_TWO:   rdata_next = mux_two_reg;
                default:            rdata_next = `CGR_RST_VAL;
            endcase
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata    <= `CGR_RST_VAL;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    // Bank routing towards the host interface
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bank_route <= `CGR_ROUTE_REGS;
        end else begin
            bank_route <= route_next;
        end
    end

    // Serial data-out pin; the host port owns timing, this owns drive style
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data_out_o  <= 1'b0;
            data_out_oe <= 1'b0;
        end else if (mcr_one_reg[`CGR_BIT_OD_OUT]) begin
            data_out_o  <= 1'b0;
            data_out_oe <= data_out_drive & ~data_out_bit;
        end else begin
            data_out_o  <= data_out_bit;
            data_out_oe <= data_out_drive;
        end
    end

    // Analog controls
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pll_enable           <= 1'b0;
            clock_doubler_enable <= 1'b0;
            ring_osc_disable     <= 1'b0;
            input_clock_enable   <= {N_IN{1'b0}};
            output_clock_enable  <= {N_OUT{1'b0}};
            soft_reset_out       <= 1'b0;
        end else begin
            pll_enable           <= pll_en_reg[`CGR_BIT_PLL_EN];
            clock_doubler_enable <= mcr_two_reg[`CGR_BIT_DBL];
            ring_osc_disable     <= mcr_one_reg[`CGR_BIT_ROSC_DIS];
            input_clock_enable   <= in_en_reg[N_IN-1:0];
            output_clock_enable  <= out_en_all[N_OUT-1:0];
            soft_reset_out       <= soft_bit;
        end
    end

    // Oscillator pin mode; the unused code leaves everything off
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            xtal_driver_en  <= 1'b0;
            osc_se_input_en <= 1'b0;
            osc_pin_b_float <= 1'b0;
        end else begin
            case (mcr_two_reg[1:0])
                `CGR_OSC_XTAL: begin
                    xtal_driver_en  <= 1'b1;
                    osc_se_input_en <= 1'b0;
                    osc_pin_b_float <= 1'b0;
                end
                `CGR_OSC_SE: begin
                    xtal_driver_en  <= 1'b0;
                    osc_se_input_en <= 1'b1;
                    osc_pin_b_float <= 1'b1;
                end
                default: begin
                    xtal_driver_en  <= 1'b0;
                    osc_se_input_en <= 1'b0;
                    osc_pin_b_float <= 1'b0;
                end
            endcase
        end
    end

    // Group mux fields: A, B, C in the first, D, E, F in the second
    always @* begin
        group_code[0] = mux_one_reg[1:0];
        group_code[1] = mux_one_reg[3:2];
        group_code[2] = mux_one_reg[5:4];
        group_code[3] = mux_two_reg[1:0];
        group_code[4] = mux_two_reg[3:2];
        group_code[5] = mux_two_reg[5:4];
    end

    // Output to group: 1-2 A, 3 B, 4-5 C, 6-7 D, 8 E, 9-10 F
    function [2:0] group_of;
        input integer idx;
        begin
            if (idx < 2)
                group_of = 3'd0;
            else if (idx < 3)
                group_of = 3'd1;
            else if (idx < 5)
                group_of = 3'd2;
            else if (idx < 7)
                group_of = 3'd3;
            else if (idx < 8)
                group_of = 3'd4;
            else
                group_of = 3'd5;
        end
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < N_OUT; gi = gi + 1) begin : g_out
            // Code 10 selects no source at all
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    out_src_int[gi]   <= 1'b0;
                    out_src_frac[gi]  <= 1'b0;
                    out_src_path2[gi] <= 1'b0;
                end else begin
                    out_src_int[gi]   <= (group_code[group_of(gi)] == `CGR_MUX_INT);
                    out_src_frac[gi]  <= (group_code[group_of(gi)] == `CGR_MUX_FRAC);
                    out_src_path2[gi] <= (group_code[group_of(gi)] == `CGR_MUX_PATH2);
                end
            end

            cgr_out_stop u_stop (
                .clk           (clk),
                .rst_b         (rst_b),
                .core_reset    (core_reset),
                .out_enable    (out_en_all[gi]),
                .src_is_global (stop_source_global[gi]),
                .global_stop   (global_stop),
                .own_stop      (per_output_stop_regs[gi]),
                .stop_int      (out_stop[gi])
            );
        end
    endgenerate

endmodule

// File: src/cgr_out_stop.v
// Internal stop control of one output clock
`timescale 1ns/100ps

module cgr_out_stop (
    input  wire clk,
    input  wire rst_b,
    input  wire core_reset,
    input  wire out_enable,
    input  wire src_is_global,
    input  wire global_stop,
    input  wire own_stop,
    output reg  stop_int
);

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stop_int <= 1'b0;
        end else if (core_reset || !out_enable) begin
            // Disabled output has its start/stop circuitry idle
            stop_int <= 1'b0;
        end else begin
            stop_int <= src_is_global & (global_stop | own_stop);
        end
    end

endmodule

// File: src/cgr_reset_ctl.v
// Reset sequencing: soft and hard reset bits, strap capture and boot start pulses
`timescale 1ns/100ps
`include "cgr_regs.vh"

module cgr_reset_ctl (
    input  wire clk,
    input  wire rst_b,
    input  wire soft_reset_bit,
    input  wire hard_reset_bit,
    output reg  core_reset,
    output reg  strap_capture,
    output reg  boot_start
);

    // Pending from pin reset onward; cleared only once all resets are gone
    reg boot_pend_reg;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            core_reset    <= 1'b1;
            boot_pend_reg <= 1'b1;
            strap_capture <= 1'b0;
            boot_start    <= 1'b0;
        end else begin
            core_reset    <= soft_reset_bit | hard_reset_bit;
            strap_capture <= 1'b0;
            boot_start    <= 1'b0;
            if (hard_reset_bit) begin
                boot_pend_reg <= 1'b1;
            end else if (boot_pend_reg && !soft_reset_bit) begin
                // Soft reset holds off the capture rather than dropping it
                boot_pend_reg <= 1'b0;
                strap_capture <= 1'b1;
                boot_start    <= 1'b1;
            end
        end
    end

endmodule

// File: test/cgr_global_cfg_props.sv
// Checker for the global configuration bank
`timescale 1ns/100ps
`include "cgr_regs.vh"
module cgr_global_cfg_props #(
    parameter N_OUT = 10,
    parameter N_IN  = 3
) (
    input wire logic             clk,
    input wire logic             rst_b,
    input wire logic             reg_wr,
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             rom_bank_select,
    input wire logic [1:0]       bank_route,
    input wire logic             data_out_bit,
    input wire logic             data_out_drive,
    input wire logic             data_out_o,
    input wire logic             data_out_oe,
    input wire logic [N_OUT-1:0] per_output_stop_regs,
    input wire logic [N_OUT-1:0] stop_source_global,
    input wire logic [N_OUT-1:0] out_stop,
    input wire logic [N_OUT-1:0] output_clock_enable,
    input wire logic [N_OUT-1:0] out_src_int,
    input wire logic [N_OUT-1:0] out_src_frac,
    input wire logic [N_OUT-1:0] out_src_path2,
    input wire logic             pll_enable,
    input wire logic             xtal_driver_en,
    input wire logic             osc_se_input_en,
    input wire logic             osc_pin_b_float,
    input wire logic             soft_reset_out,
    input wire logic             strap_capture,
    input wire logic             boot_start
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire [N_OUT-1:0] stop_mask = output_clock_enable & stop_source_global & per_output_stop_regs;
    property p_od_idle; !data_out_drive |=> !data_out_oe; endproperty
    a_od_idle: assert property (p_od_idle) else $error("data-out driven while idle");
    property p_od_level; data_out_oe |-> data_out_o == $past(data_out_bit); endproperty
    a_od_level: assert property (p_od_level) else $error("data-out wrong level");
    property p_stop_src; (out_stop & ~$past(stop_source_global)) == '0; endproperty
    a_stop_src: assert property (p_stop_src) else $error("stop on local source");
    // Two write-free cycles, since reset bits clear enables a cycle late
    property p_stop_own;
        !$past(reg_wr) && !$past(reg_wr, 2) && stop_mask != '0
            |=> (out_stop & $past(stop_mask)) == $past(stop_mask);
    endproperty
    a_stop_own: assert property (p_stop_own) else $error("own stop ignored");
    property p_osc; osc_se_input_en |-> osc_pin_b_float && !xtal_driver_en; endproperty
    a_osc: assert property (p_osc) else $error("pin mode decode wrong");
    property p_mux;
        ((out_src_int & out_src_frac) | (out_src_int & out_src_path2)
            | (out_src_frac & out_src_path2)) == '0;
    endproperty
    a_mux: assert property (p_mux) else $error("two sources at once");
    property p_boot; strap_capture |-> boot_start ##1 !strap_capture; endproperty
    a_boot: assert property (p_boot) else $error("capture without boot");
    property p_rom; rom_bank_select |=> bank_route == `CGR_ROUTE_ROM; endproperty
    a_rom: assert property (p_rom) else $error("ROM select lost");
    property p_soft;
        reg_wr && reg_addr == `CGR_OFF_MCR_ONE && bank_route == `CGR_ROUTE_REGS && !reg_wdata[6]
            |=> ##1 soft_reset_out == $past(reg_wdata[7], 2);
    endproperty
    a_soft: assert property (p_soft) else $error("soft bit not kept");
    property p_pll;
        reg_wr && reg_addr == `CGR_OFF_PLL_EN && bank_route == `CGR_ROUTE_REGS && !soft_reset_out
            |=> ##1 pll_enable == $past(reg_wdata[0], 2);
    endproperty
    a_pll: assert property (p_pll) else $error("PLL enable wrong");
    c_soft: cover property (soft_reset_out);
    c_boot: cover property (boot_start);
    c_rom: cover property (bank_route == `CGR_ROUTE_ROM);
    c_stop: cover property (out_stop != '0);
endmodule
bind cgr_global_cfg cgr_global_cfg_props #(.N_OUT(N_OUT), .N_IN(N_IN)) i_props (.*);

// File: test/cgr_host_model.sv
// Host model driving the configuration strobe port
`timescale 1ns/100ps
`include "cgr_regs.vh"
module cgr_host_model #(
    parameter XTAL_SETTLE_CYC = 64
) (
    input  wire logic       clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rd_valid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Released bus shows the inverse, so stale values never look valid
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= (a == `CGR_OFF_MCR_TWO) ? (d & 8'h0F) : d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        ok = 1'b0;
        d = 8'h00;
        for (n = 0; n < 3 && !ok; n++) begin
            #1;
            if (reg_rd_valid === 1'b1) begin
                ok = 1'b1;
                d = reg_rdata;
            end else @(posedge clk);
        end
    endtask
    // Crystal driver settling before doubler use, shortened for simulation
    task xtal_settle;
        repeat (XTAL_SETTLE_CYC) @(posedge clk);
    endtask
endmodule

// File: test/tb_clock_gen_global_config_regs.sv
// Self-checking bench for the global configuration bank
`timescale 1ns/100ps
`include "cgr_regs.vh"
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp); end end
module tb_clock_gen_global_config_regs;
    logic       clk = 0, rst_b = 0, rom_bank_select = 0, data_out_bit = 0, data_out_drive = 0;
    logic [9:0] per_output_stop_regs = '0, stop_source_global = '0;
    wire        reg_wr, reg_rd, reg_rd_valid, data_out_o, data_out_oe, pll_enable;
    wire        clock_doubler_enable, ring_osc_disable, xtal_driver_en, osc_se_input_en;
    wire        osc_pin_b_float, soft_reset_out, strap_capture, boot_start;
    wire [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire [1:0]  bank_route;
    wire [2:0]  input_clock_enable;
    wire [9:0]  out_stop, output_clock_enable, out_src_int, out_src_frac, out_src_path2;
    int         error_cnt = 0, check_count = 0, boot_cnt = 0, strap_cnt = 0;
    logic [7:0] rdv;
    logic       ok;
    cgr_global_cfg i_dut (.*);
    cgr_host_model i_host (.*);
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (boot_start === 1'b1) boot_cnt++;
        if (strap_capture === 1'b1) strap_cnt++;
    end
    task rc(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, rdv, ok);
        `CHK(ok, 1'b1)
        `CHK(rdv, e)
    endtask
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #80000;
        error_cnt++;
        final_report;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        settle;
        `CHK(boot_cnt, 1)
        for (int a = 0; a < 10; a++) rc(8'(a), `CGR_RST_VAL);
        rc(8'hFF, 8'h00);
        `CHK({output_clock_enable, pll_enable, input_clock_enable}, 14'h0000)
        $display("test reset done");
        i_host.wr(`CGR_OFF_OUT_EN_LO, 8'hFF);
        i_host.wr(`CGR_OFF_OUT_EN_HI, 8'hFF);
        i_host.wr(`CGR_OFF_PLL_EN, 8'hFF);
        i_host.wr(`CGR_OFF_IN_EN, 8'hFF);
        i_host.wr(`CGR_OFF_MCR_ONE, 8'h3E);
        settle;
        rc(`CGR_OFF_OUT_EN_HI, 8'h03);
        rc(`CGR_OFF_PLL_EN, 8'h01);
        rc(`CGR_OFF_IN_EN, 8'h07);
        rc(`CGR_OFF_MCR_ONE, 8'h2A);
        `CHK(output_clock_enable, 10'h3FF)
        `CHK({pll_enable, input_clock_enable, ring_osc_disable}, 5'h1F)
        $display("test readback done");
        @(posedge clk) stop_source_global <= 10'h155;
        settle;
        `CHK(out_stop, 10'h155)
        i_host.wr(`CGR_OFF_MCR_ONE, 8'h0A);
        @(posedge clk) per_output_stop_regs <= 10'h00F;
        settle;
        `CHK(out_stop, 10'h005)
        $display("test stop done");
        for (int m = 0; m < 8; m++) begin
            if (m == 4) i_host.wr(`CGR_OFF_MCR_ONE, 8'h08);
            @(posedge clk);
            data_out_drive <= m[1];
            data_out_bit <= m[0];
            settle;
            `CHK(data_out_oe, m[1] & ~(m < 4 && m[0]))
            if (data_out_oe === 1'b1) `CHK(data_out_o, m[0])
        end
        $display("test data pin done");
        i_host.wr(`CGR_OFF_MCR_TWO, 8'hF1);
        i_host.xtal_settle;
        i_host.wr(`CGR_OFF_MCR_TWO, 8'h05);
        settle;
        `CHK({clock_doubler_enable, xtal_driver_en, osc_se_input_en}, 3'b110)
        i_host.wr(`CGR_OFF_MCR_TWO, 8'h03);
        settle;
        `CHK({xtal_driver_en, osc_se_input_en, osc_pin_b_float}, 3'b000)
        i_host.wr(`CGR_OFF_MCR_TWO, 8'h02);
        settle;
        `CHK({clock_doubler_enable, xtal_driver_en, osc_se_input_en, osc_pin_b_float}, 4'h3)
        i_host.wr(`CGR_OFF_MCR_TWO, 8'h00);
        settle;
        `CHK({xtal_driver_en, osc_se_input_en}, 2'b00)
        $display("test oscillator done");
        for (int c = 0; c < 4; c++) begin
            i_host.wr(`CGR_OFF_MUX_ONE, {2'b00, c[1:0], c[1:0], c[1:0]});
            i_host.wr(`CGR_OFF_MUX_TWO, {2'b00, c[1:0], c[1:0], c[1:0]});
            settle;
            `CHK({out_src_int, out_src_frac, out_src_path2}, {{10{c == 0}}, {10{c == 1}}, {10{c == 3}}})
        end
        i_host.wr(`CGR_OFF_MUX_ONE, 8'hF4);
        i_host.wr(`CGR_OFF_MUX_TWO, 8'h0D);
        settle;
        `CHK({out_src_int, out_src_frac, out_src_path2}, {10'h303, 10'h064, 10'h098})
        rc(`CGR_OFF_MUX_ONE, 8'h34);
        $display("test mux done");
        i_host.wr(`CGR_OFF_BANK, 8'hFF);
        settle;
        `CHK(bank_route, `CGR_ROUTE_NVM)
        rc(`CGR_OFF_BANK, 8'h80);
        rc(`CGR_OFF_PLL_EN, 8'h00);
        i_host.wr(`CGR_OFF_PLL_EN, 8'h00);
        @(posedge clk) rom_bank_select <= 1'b1;
        settle;
        `CHK(bank_route, `CGR_ROUTE_ROM)
        @(posedge clk) rom_bank_select <= 1'b0;
        i_host.wr(`CGR_OFF_BANK, 8'h00);
        settle;
        `CHK(bank_route, `CGR_ROUTE_REGS)
        rc(`CGR_OFF_PLL_EN, 8'h01);
        $display("test bank done");
        i_host.wr(`CGR_OFF_MCR_ONE, 8'h80);
        i_host.wr(`CGR_OFF_PLL_EN, 8'h01);
        settle;
        `CHK({soft_reset_out, pll_enable, output_clock_enable}, 12'h800)
        rc(`CGR_OFF_MCR_ONE, 8'h80);
        rc(`CGR_OFF_OUT_EN_LO, 8'h00);
        i_host.wr(`CGR_OFF_MCR_ONE, 8'h00);
        settle;
        `CHK({boot_cnt, strap_cnt}, {32'd1, 32'd1})
        i_host.wr(`CGR_OFF_OUT_EN_LO, 8'h01);
        i_host.wr(`CGR_OFF_MCR_ONE, 8'h40);
        settle;
        rc(`CGR_OFF_OUT_EN_LO, 8'h00);
        rc(`CGR_OFF_MCR_ONE, 8'h40);
        i_host.wr(`CGR_OFF_MCR_ONE, 8'h00);
        settle;
        `CHK({boot_cnt, strap_cnt}, {32'd2, 32'd2})
        @(posedge clk) rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        settle;
        `CHK({boot_cnt, strap_cnt}, {32'd3, 32'd3})
        $display("test resets done");
        final_report;
    end
endmodule
